/* core/ivp_defines.vh */
`ifndef IVP_DEFINES_VH
`define IVP_DEFINES_VH

// Vector numbering.
`define IVP_NUM_VECTORS     32
`define IVP_NUM_W           5
`define IVP_NUM_RANKS       28

// Named vector numbers.
`define IVP_RESET_NUM       5'h00
`define IVP_NMI_NUM         5'h01
`define IVP_BUS_ERR_NUM     5'h18
`define IVP_DATA_LOG_NUM    5'h19
`define IVP_OS_SVC_NUM      5'h1A
`define IVP_RSVD_A_NUM      5'h1B
`define IVP_RSVD_B_NUM      5'h1C
`define IVP_EMU_NMI_NUM     5'h1D
`define IVP_SW_ONLY_A_NUM   5'h1E
`define IVP_SW_ONLY_B_NUM   5'h1F

// Vectors that hardware may raise and that carry a priority rank (1..26 and 29).
`define IVP_HW_RANKED_MASK  32'h27FFFFFE

// Hardware priority order, rank 0 (highest) in the low five bits.
`define IVP_RANK_ORDER {5'h1A, 5'h19, 5'h17, 5'h16, 5'h0F, 5'h0E, 5'h15, 5'h14, \
                        5'h0D, 5'h0C, 5'h13, 5'h0B, 5'h0A, 5'h09, 5'h12, 5'h08, \
                        5'h07, 5'h06, 5'h11, 5'h05, 5'h04, 5'h03, 5'h10, 5'h02, \
                        5'h18, 5'h01, 5'h1D, 5'h00}

// Address formation.
`define IVP_PAGE_W          16
`define IVP_ADDR_W          24
`define IVP_VEC_BYTES_LOG2  3
`define IVP_SEC_PAGE_SEL    2'h2

// Fetched vector word layout, byte 0 in the top lane.
`define IVP_BYTE0_HI        31
`define IVP_BYTE0_LO        24
`define IVP_ISR_ADDR_HI     23
`define IVP_ISR_ADDR_LO     0
`define IVP_FETCH_W         32

// Reset values.
`define IVP_STACK_MODE_RST  8'h00
`define IVP_ADDR_RST        24'h000000

`endif

/* core/ivp_prio_enc.v */
`timescale 1ns/10ps
`include "ivp_defines.vh"

// Fixed-priority picker over the ranked hardware vectors.
module ivp_prio_enc (
  input  wire [`IVP_NUM_VECTORS-1:0] pend,
  output wire                        found,
  output wire [`IVP_NUM_W-1:0]       num
);

  // Rank table, one five-bit vector number per rank.
  localparam [`IVP_NUM_RANKS*`IVP_NUM_W-1:0] ORDER = `IVP_RANK_ORDER;

  // Running flags and accumulated winner through the rank chain.
  wire [`IVP_NUM_RANKS:0]              above;
  wire [(`IVP_NUM_RANKS+1)*`IVP_NUM_W-1:0] acc;

  assign above[0]              = 1'b0;
  assign acc[`IVP_NUM_W-1:0]   = {`IVP_NUM_W{1'b0}};

  // Each rank wins only when nothing above it is pending; the chain keeps it one-hot.
  genvar i;
  generate
    for (i = 0; i < `IVP_NUM_RANKS; i = i + 1) begin : g_rank
      wire [`IVP_NUM_W-1:0] vec = ORDER[i*`IVP_NUM_W +: `IVP_NUM_W];
      wire                  hit = pend[vec];
      wire                  win = hit & ~above[i];
      assign above[i+1] = above[i] | hit;
      assign acc[(i+1)*`IVP_NUM_W +: `IVP_NUM_W] =
        acc[i*`IVP_NUM_W +: `IVP_NUM_W] | ({`IVP_NUM_W{win}} & vec);
    end
  endgenerate

  assign found = above[`IVP_NUM_RANKS];
  assign num   = acc[`IVP_NUM_RANKS*`IVP_NUM_W +: `IVP_NUM_W];

endmodule // ivp_prio_enc

/* core/ivp_vector_unit.v */
`timescale 1ns/10ps
`include "ivp_defines.vh"

module ivp_vector_unit (
  input  wire                        clk_sys,
  input  wire                        rst_n,
  input  wire [`IVP_NUM_VECTORS-1:0] hw_irq_pin,
  input  wire                        sw_int_req,
  input  wire [`IVP_NUM_W-1:0]       sw_int_num,
  input  wire                        cpu_accept,
  input  wire                        data_stack_pointer_wr,
  input  wire                        system_stack_pointer_wr,
  input  wire [`IVP_PAGE_W-1:0]      primary_vector_page_pointer,
  input  wire [`IVP_PAGE_W-1:0]      secondary_vector_page_pointer,
  input  wire                        fetch_rdy,
  input  wire [`IVP_FETCH_W-1:0]     fetch_data,
  output reg                         ack_valid_reg,
  output reg  [`IVP_NUM_W-1:0]       ack_num_reg,
  output reg                         fetch_req_reg,
  output reg  [`IVP_ADDR_W-1:0]      fetch_addr_reg,
  output reg                         isr_start_valid_reg,
  output reg  [`IVP_ADDR_W-1:0]      isr_start_addr_reg,
  output reg  [`IVP_NUM_W-1:0]       isr_num_reg,
  output reg                         stack_mode_valid_reg,
  output reg  [7:0]                  stack_mode_reg,
  output reg                         ints_enabled_reg,
  output reg                         busy_reg
);

  ////////////////////////////////////////////////////////////////////////////////
  // States, one-hot.
  // One-hot codes make each state test a single bit.
  // An illegal code falls back to idle.
  // Only one vector is in flight, so three states suffice.
  localparam [2:0] ST_IDLE  = 3'h1;  // Waiting for a request and a CPU boundary.
  localparam [2:0] ST_ADDR  = 3'h2;  // Forming the vector address.
  localparam [2:0] ST_FETCH = 3'h4;  // Waiting for the vector word.

  ////////////////////////////////////////////////////////////////////////////////
  // Declarations.
  // Request and sequencer registers have a _next value from a combinational process;
  // the clocked processes copy them; the synchroniser, stack flags, ack_num_reg and busy_reg load directly.
  reg  [`IVP_NUM_VECTORS-1:0] sync1_reg;      // First synchroniser stage.
  reg  [`IVP_NUM_VECTORS-1:0] sync2_reg;      // Second synchroniser stage.
  reg  [`IVP_NUM_VECTORS-1:0] prev_reg;       // Delayed copy for edge detection.
  reg  [`IVP_NUM_VECTORS-1:0] pend_reg;       // Latched hardware requests.
  reg  [`IVP_NUM_VECTORS-1:0] pend_next;      // Next pending set.
  reg                         reset_pend_reg; // Reset vector still owed.
  reg                         reset_pend_next;
  reg                         sw_pend_reg;    // Software request held.
  reg                         sw_pend_next;
  reg  [`IVP_NUM_W-1:0]       sw_num_reg;     // Number of the held software request.
  reg  [`IVP_NUM_W-1:0]       sw_num_next;
  reg                         sp_done_reg;    // Data stack pointer has been written.
  reg                         ssp_done_reg;   // System stack pointer has been written.
  reg  [2:0]                  state_reg;      // Sequencer state.
  reg  [2:0]                  state_next;
  reg  [`IVP_NUM_W-1:0]       cur_num_reg;    // Vector in service.
  reg  [`IVP_NUM_W-1:0]       cur_num_next;
  reg                         ack_valid_next;
  reg                         fetch_req_next;
  reg  [`IVP_ADDR_W-1:0]      fetch_addr_next;
  reg                         isr_start_valid_next;
  reg  [`IVP_ADDR_W-1:0]      isr_start_addr_next;
  reg  [`IVP_NUM_W-1:0]       isr_num_next;
  reg                         stack_mode_valid_next;
  reg  [7:0]                  stack_mode_next;
  reg  [`IVP_NUM_VECTORS-1:0] clr_vec;        // Pending bit taken this cycle.
  reg                         take;           // A request is acknowledged now.
  reg  [`IVP_NUM_W-1:0]       take_num;       // Number of that request.
  reg                         sw_clr;         // Held software request taken now.
  reg  [`IVP_PAGE_W-1:0]      page;           // Page chosen for the vector.
  wire [`IVP_NUM_VECTORS-1:0] hw_rise;        // Rising request edges.
  wire                        hw_found;       // Some ranked request is pending.
  wire [`IVP_NUM_W-1:0]       hw_num;         // Highest ranked pending request.
  wire                        sw_num_ok;      // Incoming software number is usable.
  wire                        sw_is_reset;    // Held software request is a reset.
  wire                        ints_en;        // Both stacks are initialised.

  ////////////////////////////////////////////////////////////////////////////////
  // Request sources.

  // A pin edge takes three clock edges to become pending: two to
  // synchronise and one for the edge stage. Sources firing soon
  // after reset still keep their request, as every stage resets low.
  // Edges are taken from the second stage only; the first stage feeds nothing else.
  assign hw_rise = sync2_reg & ~prev_reg;

  // Reserved numbers are refused; everything else, reset included, may be raised by software.
  assign sw_num_ok = (sw_int_num != `IVP_RSVD_A_NUM) &&
                     (sw_int_num != `IVP_RSVD_B_NUM);

  // A software request for vector 0 is served like the owed hardware reset, ahead of the stack gate.
  assign sw_is_reset = sw_pend_reg && (sw_num_reg == `IVP_RESET_NUM);

  // Both stack writes must have been seen.
  assign ints_en = sp_done_reg & ssp_done_reg;

  // Picks the winner among latched hardware requests.
  // A request latched after arbitration waits for the
  // next idle cycle.
  ivp_prio_enc u_prio (
    .pend  (pend_reg),
    .found (hw_found),
    .num   (hw_num)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Arbitration and sequencing.

  // Arbitration reads registered state and cpu_accept only, so the winner
  // cannot change within its acknowledge cycle.
  // Reset outranks all; a software request is an executed instruction, so it goes
  // ahead of hardware; hardware follows its fixed rank.
  always @* begin
    take     = 1'b0;
    take_num = `IVP_RESET_NUM;
    sw_clr   = 1'b0;
    clr_vec  = {`IVP_NUM_VECTORS{1'b0}};
    if ((state_reg == ST_IDLE) && cpu_accept) begin
      if (reset_pend_reg || sw_is_reset) begin
        take     = 1'b1;
        take_num = `IVP_RESET_NUM;
        sw_clr   = sw_is_reset;
      end else if (ints_en && sw_pend_reg) begin
        take     = 1'b1;
        take_num = sw_num_reg;
        sw_clr   = 1'b1;
      end else if (ints_en && hw_found) begin
        take     = 1'b1;
        take_num = hw_num;
        clr_vec[hw_num] = 1'b1;
      end
    end
  end

  // Pending bookkeeping; a new edge on a bit being cleared keeps the bit set.
  // Letting the set win means an edge in the cycle of its own
  // acknowledge is served again rather than lost.
  // Reserved and software-only numbers are masked off the pins.
  always @* begin
    pend_next = (pend_reg & ~clr_vec) |
                (hw_rise & `IVP_HW_RANKED_MASK);
    reset_pend_next = reset_pend_reg;
    if (take && (take_num == `IVP_RESET_NUM)) begin
      reset_pend_next = 1'b0;
    end
    sw_pend_next = sw_pend_reg;
    sw_num_next  = sw_num_reg;
    if (sw_clr) begin
      sw_pend_next = 1'b0;
    end
    // Only one software request is held; another is ignored until it is taken.
    // Reserved numbers never enter the holding register.
    if (sw_int_req && sw_num_ok && (!sw_pend_reg || sw_clr)) begin
      sw_pend_next = 1'b1;
      sw_num_next  = sw_int_num;
    end
  end

  // Page choice: vectors 16 to 23 live on the secondary page, the rest on the primary.
  // It uses the vector in service, so a new request cannot
  // move a fetch already under way.
  always @* begin
    if (cur_num_reg[`IVP_NUM_W-1:`IVP_NUM_W-2] == `IVP_SEC_PAGE_SEL) begin
      page = secondary_vector_page_pointer;
    end else begin
      page = primary_vector_page_pointer;
    end
  end

  // Sequencer: acknowledge, then form the address, then fetch the vector word.
  // There is no fetch timeout: a memory that never answers
  // leaves the unit busy until the next reset.
  // Pulse outputs default low; the rest hold their value.
  always @* begin
    state_next            = state_reg;
    cur_num_next          = cur_num_reg;
    ack_valid_next        = 1'b0;
    fetch_req_next        = fetch_req_reg;
    fetch_addr_next       = fetch_addr_reg;
    isr_start_valid_next  = 1'b0;
    isr_start_addr_next   = isr_start_addr_reg;
    isr_num_next          = isr_num_reg;
    stack_mode_valid_next = 1'b0;
    stack_mode_next       = stack_mode_reg;
    case (state_reg)
      ST_IDLE: begin
        // The acknowledge and its number leave on one edge.
        if (take) begin
          ack_valid_next = 1'b1;
          cur_num_next   = take_num;
          state_next     = ST_ADDR;
        end
      end
      ST_ADDR: begin
        // Page pointers are sampled here, after the acknowledge, not earlier.
        fetch_addr_next = {page, cur_num_reg,
                           {`IVP_VEC_BYTES_LOG2{1'b0}}};
        fetch_req_next  = 1'b1;
        state_next      = ST_FETCH;
      end
      ST_FETCH: begin
        // Only the first word is read; bytes 4 to 7 hold padding and are never needed.
        if (fetch_rdy) begin
          fetch_req_next       = 1'b0;
          isr_start_valid_next = 1'b1;
          isr_start_addr_next  = fetch_data[`IVP_ISR_ADDR_HI:`IVP_ISR_ADDR_LO];
          isr_num_next         = cur_num_reg;
          if (cur_num_reg == `IVP_RESET_NUM) begin
            stack_mode_valid_next = 1'b1;
            stack_mode_next       = fetch_data[`IVP_BYTE0_HI:`IVP_BYTE0_LO];
          end
          // Byte 0 of any other vector is dropped here on purpose.
          state_next = ST_IDLE;
        end
      end
      default: begin
        // An illegal code drops any fetch and returns to idle.
        state_next     = ST_IDLE;
        fetch_req_next = 1'b0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Registers.
  // Every process here resets asynchronously to constants.

  // Synchroniser and edge detector for the request pins.
  // The edge stage resets low like the idle pins, so no
  // false edge follows the release of reset.
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sync1_reg <= {`IVP_NUM_VECTORS{1'b0}};
      sync2_reg <= {`IVP_NUM_VECTORS{1'b0}};
      prev_reg  <= {`IVP_NUM_VECTORS{1'b0}};
    end else begin
      sync1_reg <= hw_irq_pin;
      sync2_reg <= sync1_reg;
      prev_reg  <= sync2_reg;
    end
  end

  // Stack initialisation tracking; only a hardware reset rearms it.
  // The enable is registered so the port comes from a flip-flop.
  // A software reset leaves these flags alone on purpose.
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sp_done_reg      <= 1'b0;
      ssp_done_reg     <= 1'b0;
      ints_enabled_reg <= 1'b0;
    end else begin
      if (data_stack_pointer_wr) begin
        sp_done_reg <= 1'b1;
      end
      if (system_stack_pointer_wr) begin
        ssp_done_reg <= 1'b1;
      end
      // Looks ahead one write so the port matches the internal enable.
      ints_enabled_reg <= (sp_done_reg | data_stack_pointer_wr) &
                          (ssp_done_reg | system_stack_pointer_wr);
    end
  end

  // Request state; a hardware reset leaves the reset vector owed.
  // The owed vector is served even before the stacks are set.
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pend_reg       <= {`IVP_NUM_VECTORS{1'b0}};
      reset_pend_reg <= 1'b1;
      sw_pend_reg    <= 1'b0;
      sw_num_reg     <= `IVP_RESET_NUM;
    end else begin
      pend_reg       <= pend_next;
      reset_pend_reg <= reset_pend_next;
      sw_pend_reg    <= sw_pend_next;
      sw_num_reg     <= sw_num_next;
    end
  end

  // Sequencer and output registers.
  // No port has a combinational path from the request inputs.
  // The acknowledged number follows the vector in service
  // and stays valid until the next acknowledge.
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_reg            <= ST_IDLE;
      cur_num_reg          <= `IVP_RESET_NUM;
      ack_valid_reg        <= 1'b0;
      ack_num_reg          <= `IVP_RESET_NUM;
      fetch_req_reg        <= 1'b0;
      fetch_addr_reg       <= `IVP_ADDR_RST;
      isr_start_valid_reg  <= 1'b0;
      isr_start_addr_reg   <= `IVP_ADDR_RST;
      isr_num_reg          <= `IVP_RESET_NUM;
      stack_mode_valid_reg <= 1'b0;
      stack_mode_reg       <= `IVP_STACK_MODE_RST;
      busy_reg             <= 1'b0;
    end else begin
      state_reg            <= state_next;
      cur_num_reg          <= cur_num_next;
      ack_valid_reg        <= ack_valid_next;
      ack_num_reg          <= cur_num_next;
      fetch_req_reg        <= fetch_req_next;
      fetch_addr_reg       <= fetch_addr_next;
      isr_start_valid_reg  <= isr_start_valid_next;
      isr_start_addr_reg   <= isr_start_addr_next;
      isr_num_reg          <= isr_num_next;
      stack_mode_valid_reg <= stack_mode_valid_next;
      stack_mode_reg       <= stack_mode_next;
      busy_reg             <= (state_next != ST_IDLE);
    end
  end

endmodule // ivp_vector_unit

/* testbench/interrupt_vector_priority_unit_tb.sv */
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////
// Bench: reset vector, stack gating, every software vector, hardware ranking.
module interrupt_vector_priority_unit_tb;
  reg  [31:0] hw_irq_pin, r, seed;
  reg  [15:0] pri_pg, sec_pg;
  reg  [4:0]  sw_int_num, rank [0:26];
  reg  [2:0]  lag;
  reg         clk_sys, rst_n, sw_int_req, cpu_accept, dsp_wr, ssp_wr;
  wire        fetch_rdy, ack_valid, fetch_req, isr_valid, mode_valid, ints_en, busy;
  wire [31:0] fetch_data;
  wire [23:0] fetch_addr, isr_addr;
  wire [4:0]  ack_num, isr_num;
  wire [7:0]  stack_mode;
  integer     num_errors, n_checks, i, j;
  ivp_vector_unit ivp_vector_unit_i (.clk_sys(clk_sys), .rst_n(rst_n),
    .hw_irq_pin(hw_irq_pin), .sw_int_req(sw_int_req), .sw_int_num(sw_int_num),
    .cpu_accept(cpu_accept), .data_stack_pointer_wr(dsp_wr), .system_stack_pointer_wr(ssp_wr),
    .primary_vector_page_pointer(pri_pg), .secondary_vector_page_pointer(sec_pg),
    .fetch_rdy(fetch_rdy), .fetch_data(fetch_data), .ack_valid_reg(ack_valid),
    .ack_num_reg(ack_num), .fetch_req_reg(fetch_req), .fetch_addr_reg(fetch_addr),
    .isr_start_valid_reg(isr_valid), .isr_start_addr_reg(isr_addr), .isr_num_reg(isr_num),
    .stack_mode_valid_reg(mode_valid), .stack_mode_reg(stack_mode),
    .ints_enabled_reg(ints_en), .busy_reg(busy));
  ivp_mem_model ivp_mem_model_i (.clk_sys(clk_sys), .rst_n(rst_n), .fetch_req_reg(fetch_req),
    .fetch_addr_reg(fetch_addr), .lag(lag), .fetch_rdy(fetch_rdy), .fetch_data(fetch_data));
  ////////////////////////////////////////////////////////////////
  // Xorshift source; the seed is fixed so every run repeats.
  function automatic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    rnd = seed;
  endfunction
  // Expected slot address of vector n under the present page pointers.
  function automatic [23:0] exp_addr(input [4:0] n);
    exp_addr = {(n >= 5'h10 && n <= 5'h17) ? sec_pg : pri_pg, n, 3'h0};
  endfunction
  task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks = n_checks + 1;
    if (got !== exp) begin
      num_errors = num_errors + 1;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Waits for the next acknowledge, then checks the whole transfer of vector n.
  task automatic serve(input [4:0] n);
    integer     k;
    logic [23:0] a;
    a = exp_addr(n);
    for (k = 0; k < 60 && ack_valid !== 1'b1; k++) @(negedge clk_sys);
    cmp("ack", 1, ack_valid);
    cmp("ack_num", n, ack_num);
    cmp("busy", 1, busy);
    for (k = 0; k < 60 && isr_valid !== 1'b1; k++) @(negedge clk_sys);
    cmp("isr_num", n, isr_num);
    cmp("isr_addr", a ^ 24'h3C5A96, isr_addr);
    cmp("mode_valid", n == 5'h00, mode_valid);
    cmp("busy_end", 0, busy);
    if (n == 5'h00) cmp("stack_mode", a[10:3] ^ 8'h5C, stack_mode);
    @(negedge clk_sys);
  endtask
  // Counts acknowledges over c cycles; none are allowed.
  task automatic quiet(input integer c);
    integer k, hits;
    hits = 0;
    for (k = 0; k < c; k++) begin
      @(negedge clk_sys);
      hits = hits + ack_valid;
    end
    cmp("no_ack", 0, hits);
  endtask
  // One-cycle software request pulse.
  task automatic sw(input [4:0] n);
    @(posedge clk_sys);
    sw_int_req <= 1'b1;
    sw_int_num <= n;
    @(posedge clk_sys);
    sw_int_req <= 1'b0;
    @(negedge clk_sys);
  endtask
  task conclude;
    if (num_errors == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  // Watchdog: the sequence needs about five thousand cycles.
  initial begin
    #(100 * 40000);
    num_errors = num_errors + 1;
    conclude;
  end
  initial begin
    {rst_n, sw_int_req, dsp_wr, ssp_wr, lag, sw_int_num, hw_irq_pin} = 0;
    {num_errors, n_checks} = 0;
    {cpu_accept, seed, pri_pg, sec_pg} = {1'b1, 32'h2A, 16'h1234, 16'hABCD};
    rank = '{5'h1D, 5'h01, 5'h18, 5'h02, 5'h10, 5'h03, 5'h04, 5'h05, 5'h11, 5'h06, 5'h07,
             5'h08, 5'h12, 5'h09, 5'h0A, 5'h0B, 5'h13, 5'h0C, 5'h0D, 5'h14, 5'h15, 5'h0E,
             5'h0F, 5'h16, 5'h17, 5'h19, 5'h1A};
    repeat (6) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(negedge clk_sys);
    serve(5'h00);
    // Vector 5 stays held until both stack pointers have been written.
    sw(5'h05);
    quiet(20);
    cmp("ints_en", 0, ints_en);
    @(posedge clk_sys) dsp_wr <= 1'b1;
    @(posedge clk_sys) dsp_wr <= 1'b0;
    quiet(8);
    @(posedge clk_sys) ssp_wr <= 1'b1;
    @(posedge clk_sys) ssp_wr <= 1'b0;
    serve(5'h05);
    cmp("ints_en", 1, ints_en);
    // Every software number on random pages with a random memory lag.
    for (i = 0; i < 32; i++) begin
      r = rnd();
      @(posedge clk_sys);
      {sec_pg, pri_pg} <= r;
      lag <= r[2:0];
      sw(i[4:0]);
      if (i == 27 || i == 28) quiet(20);
      else serve(i[4:0]);
    end
    // Pending pins, all at first and then random sets, drain in rank order.
    for (j = 0; j < 40; j++) begin
      r = (j == 0) ? 32'hFFFFFFFF : rnd();
      @(posedge clk_sys);
      cpu_accept <= 1'b0;
      hw_irq_pin <= r;
      lag <= r[6:4];
      repeat (6) @(posedge clk_sys);
      hw_irq_pin <= 32'h0;
      cpu_accept <= 1'b1;
      @(negedge clk_sys);
      for (i = 0; i < 27; i++) if (r[rank[i]]) serve(rank[i]);
      quiet(10);
    end
    // A second reset rearms the reset vector and the stack gate.
    @(posedge clk_sys) rst_n <= 1'b0;
    repeat (6) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(negedge clk_sys);
    cmp("ints_en_rst", 0, ints_en);
    serve(5'h00);
    sw(5'h03);
    quiet(20);
    conclude;
  end
endmodule // interrupt_vector_priority_unit_tb

/* testbench/ivp_checker.sv */
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////
// Passive monitor of the vector unit, tied to its ports only.
module ivp_checker (
  input logic        clk_sys,
  input logic        rst_n,
  input logic [31:0] hw_irq_pin,
  input logic        sw_int_req,
  input logic [4:0]  sw_int_num,
  input logic        cpu_accept,
  input logic        data_stack_pointer_wr,
  input logic        system_stack_pointer_wr,
  input logic [15:0] primary_vector_page_pointer,
  input logic [15:0] secondary_vector_page_pointer,
  input logic        fetch_rdy,
  input logic [31:0] fetch_data,
  input logic        ack_valid_reg,
  input logic [4:0]  ack_num_reg,
  input logic        fetch_req_reg,
  input logic [23:0] fetch_addr_reg,
  input logic        isr_start_valid_reg,
  input logic [23:0] isr_start_addr_reg,
  input logic [4:0]  isr_num_reg,
  input logic        stack_mode_valid_reg,
  input logic [7:0]  stack_mode_reg,
  input logic        ints_enabled_reg,
  input logic        busy_reg
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  wire        take  = fetch_req_reg && fetch_rdy;  // Memory answers this cycle.
  wire [23:0] fd_isr  = fetch_data[23:0];          // Routine address lanes.
  wire [7:0]  fd_mode = fetch_data[31:24];         // Byte zero lane.
  // The page is checked at the rise of the fetch; pointers are held while busy.
  property p_ack_fetch;
    ack_valid_reg |=> $rose(fetch_req_reg) && fetch_addr_reg[7:0] == {$past(ack_num_reg), 3'h0};
  endproperty
  a_ack_fetch: assert property (p_ack_fetch) else $error("fetch slot wrong after ack");
  property p_pri_page;
    $rose(fetch_req_reg) && fetch_addr_reg[7:6] != 2'h2 |->
      fetch_addr_reg[23:8] == primary_vector_page_pointer;
  endproperty
  a_pri_page: assert property (p_pri_page) else $error("primary page wrong");
  property p_sec_page;
    $rose(fetch_req_reg) && fetch_addr_reg[7:6] == 2'h2 |->
      fetch_addr_reg[23:8] == secondary_vector_page_pointer;
  endproperty
  a_sec_page: assert property (p_sec_page) else $error("secondary page wrong");
  property p_isr;
    take |=> isr_start_valid_reg && !fetch_req_reg && isr_start_addr_reg == $past(fd_isr)
      && isr_num_reg == $past(ack_num_reg);
  endproperty
  a_isr: assert property (p_isr) else $error("routine start not taken from word");
  property p_mode;
    take && ack_num_reg == 5'h00 |=> stack_mode_valid_reg && stack_mode_reg == $past(fd_mode);
  endproperty
  a_mode: assert property (p_mode) else $error("stack mode not taken");
  property p_byte0_ign;
    take && ack_num_reg != 5'h00 |=> !stack_mode_valid_reg && $stable(stack_mode_reg);
  endproperty
  a_byte0_ign: assert property (p_byte0_ign) else $error("byte zero used");
  property p_single;
    fetch_req_reg |-> !ack_valid_reg && busy_reg;
  endproperty
  a_single: assert property (p_single) else $error("ack during service");
  property p_gate;
    ack_valid_reg && ack_num_reg != 5'h00 |-> ints_enabled_reg;
  endproperty
  a_gate: assert property (p_gate) else $error("ack before stacks set");
  property p_rsvd;
    ack_valid_reg |-> ack_num_reg != 5'h1B && ack_num_reg != 5'h1C;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved vector served");
  c_reset: cover property (take && ack_num_reg == 5'h00);
  c_sec: cover property ($rose(fetch_req_reg) && fetch_addr_reg[7:6] == 2'h2);
  c_emu: cover property (ack_valid_reg && ack_num_reg == 5'h1D);
endmodule // ivp_checker

bind ivp_vector_unit ivp_checker ivp_checker_i (
  .clk_sys(clk_sys), .rst_n(rst_n), .hw_irq_pin(hw_irq_pin), .sw_int_req(sw_int_req),
  .sw_int_num(sw_int_num), .cpu_accept(cpu_accept), .fetch_rdy(fetch_rdy),
  .data_stack_pointer_wr(data_stack_pointer_wr), .fetch_data(fetch_data),
  .system_stack_pointer_wr(system_stack_pointer_wr),
  .primary_vector_page_pointer(primary_vector_page_pointer),
  .secondary_vector_page_pointer(secondary_vector_page_pointer),
  .ack_valid_reg(ack_valid_reg), .ack_num_reg(ack_num_reg), .fetch_req_reg(fetch_req_reg),
  .fetch_addr_reg(fetch_addr_reg), .isr_start_valid_reg(isr_start_valid_reg),
  .isr_start_addr_reg(isr_start_addr_reg), .isr_num_reg(isr_num_reg), .busy_reg(busy_reg),
  .stack_mode_valid_reg(stack_mode_valid_reg), .stack_mode_reg(stack_mode_reg),
  .ints_enabled_reg(ints_enabled_reg));

/* testbench/ivp_mem_model.sv */
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////
// Program memory holding the vector table; answers a fetch after lag cycles.
module ivp_mem_model (
  input  wire        clk_sys,
  input  wire        rst_n,
  input  wire        fetch_req_reg,
  input  wire [23:0] fetch_addr_reg,
  input  wire [2:0]  lag,
  output reg         fetch_rdy,
  output reg  [31:0] fetch_data
);
  reg       done_reg;  // Word already returned for this fetch.
  reg [2:0] cnt_reg;   // Cycles waited so far.
  // Slot words are derived from the address, so a wrong slot shows as a wrong routine.
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      fetch_rdy  <= 1'b0;
      fetch_data <= 32'h0;
      done_reg   <= 1'b0;
      cnt_reg    <= 3'h0;
    end else if (fetch_req_reg && !done_reg && cnt_reg == lag) begin
      fetch_rdy  <= 1'b1;
      fetch_data <= {fetch_addr_reg[10:3] ^ 8'h5C, fetch_addr_reg ^ 24'h3C5A96};
      done_reg   <= 1'b1;
    end else begin
      // Bytes 4..7 hold no-op fill in the next word, never fetched.
      // Off the answer the bus toggles, so a late sample never matches by luck.
      fetch_rdy  <= 1'b0;
      fetch_data <= ~fetch_data;
      done_reg   <= done_reg && fetch_req_reg;
      cnt_reg    <= (fetch_req_reg && !done_reg) ? cnt_reg + 3'h1 : 3'h0;
    end
  end
endmodule // ivp_mem_model
